// ---- verilog/sma_pkg.sv ----
// constants and types for the static and reserved multicast table access
// assumes one core clock and an active-low asynchronous reset
package sma_pkg;
    // register offsets
    localparam logic [11:0] SMA_OFS_CTRL = 12'h41c;
    localparam logic [11:0] SMA_OFS_DATA1 = 12'h420;
    localparam logic [11:0] SMA_OFS_DATA2 = 12'h424;
    localparam logic [11:0] SMA_OFS_DATA3 = 12'h428;
    localparam logic [11:0] SMA_OFS_DATA4 = 12'h42c;
    // control register fields
    localparam int SMA_CTRL_IDX_LSB = 0;
    localparam int SMA_IDX_W = 6;
    localparam int SMA_CTRL_GO_BIT = 7;
    localparam int SMA_CTRL_TBL_BIT = 8;
    localparam int SMA_CTRL_ACT_BIT = 9;
    // writable bits of each data register
    localparam logic [31:0] SMA_D1_MASK = 32'hfc00_0007;
    localparam logic [31:0] SMA_D2_MASK = 32'hc000_007f;
    localparam logic [31:0] SMA_D3_MASK = 32'h007f_ffff;
    localparam logic [31:0] SMA_D4_MASK = 32'hffff_ffff;
    localparam logic [31:0] SMA_RST_WORD = 32'h0000_0000;
    // entry fields
    localparam int SMA_VALID_BIT = 31;
    localparam int SMA_SRC_DROP_BIT = 30;
    localparam int SMA_DST_DROP_BIT = 29;
    localparam int SMA_PRIO_LSB = 26;
    localparam int SMA_PRIO_W = 3;
    localparam int SMA_STG_LSB = 0;
    localparam int SMA_STG_W = 3;
    localparam int SMA_OVR_BIT = 31;
    localparam int SMA_MGME_BIT = 30;
    localparam int SMA_FWD_LSB = 0;
    localparam int SMA_PORTS = 7;
    localparam int SMA_FID_LSB = 16;
    localparam int SMA_FID_W = 7;
    localparam int SMA_MACH_W = 16;
    localparam int SMA_MC_BIT = 40;
    // table sizes
    localparam int SMA_ST_ENTRIES = 16;
    localparam int SMA_ST_IDX_W = 4;
    localparam int SMA_RMC_ADDRS = 48;
    localparam int SMA_RMC_GROUPS = 8;
    localparam int SMA_RMC_PER_GRP = 6;
    localparam logic [39:0] SMA_RMC_PREFIX = 40'h01_80c2_0000;
    typedef enum logic [0:0] {
        SMA_IDLE = 1'b0,
        SMA_EXEC = 1'b1
    } sma_state_t;
endpackage

// ---- verilog/sma_rmc_table.sv ----
// reserved multicast forwarding table, one port mask per fixed group
// assumes writes come from the control engine of the table access block
`timescale 1ns/1ps
`default_nettype none
module sma_rmc_table (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic wr_i,
    input wire logic [sma_pkg::SMA_IDX_W-1:0] wr_idx_i,
    input wire logic [sma_pkg::SMA_PORTS-1:0] wr_mask_i,
    input wire logic [sma_pkg::SMA_IDX_W-1:0] rd_idx_i,
    output logic [sma_pkg::SMA_PORTS-1:0] rd_mask_o,
    input wire logic [7:0] lkp_low_i,
    output logic lkp_in_range_o,
    output logic [sma_pkg::SMA_PORTS-1:0] lkp_mask_o
);
    import sma_pkg::*;
    logic [SMA_PORTS-1:0] grp_mask_r [SMA_RMC_GROUPS];
    logic [2:0] wr_grp;
    logic [2:0] rd_grp;
    logic [2:0] lkp_grp;
    logic wr_ok;
    logic rd_ok;

    // address to group mapping
    assign wr_grp = 3'(wr_idx_i / SMA_IDX_W'(SMA_RMC_PER_GRP));
    assign rd_grp = 3'(rd_idx_i / SMA_IDX_W'(SMA_RMC_PER_GRP));
    assign lkp_grp = 3'(lkp_low_i / 8'(SMA_RMC_PER_GRP));
    assign wr_ok = wr_idx_i < SMA_IDX_W'(SMA_RMC_ADDRS);
    assign rd_ok = rd_idx_i < SMA_IDX_W'(SMA_RMC_ADDRS);
    assign lkp_in_range_o = lkp_low_i < 8'(SMA_RMC_ADDRS);
    assign rd_mask_o = rd_ok ? grp_mask_r[rd_grp] : '0;
    assign lkp_mask_o = lkp_in_range_o ? grp_mask_r[lkp_grp] : '0;

    genvar g;
    generate
        for (g = 0; g < SMA_RMC_GROUPS; g++) begin : g_grp
            // one store per group, shared by its addresses
            always_ff @(posedge core_clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    grp_mask_r[g] <= '0;
                end else if (wr_i && wr_ok && wr_grp == 3'(g)) begin
                    grp_mask_r[g] <= wr_mask_i;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ---- verilog/sma_static_lookup.sv ----
// parallel search of the static address table for a destination and source
// assumes entry words are the stored data register images
`timescale 1ns/1ps
`default_nettype none
module sma_static_lookup (
    input wire logic [31:0] ent_w1_i [sma_pkg::SMA_ST_ENTRIES],
    input wire logic [31:0] ent_w2_i [sma_pkg::SMA_ST_ENTRIES],
    input wire logic [31:0] ent_w3_i [sma_pkg::SMA_ST_ENTRIES],
    input wire logic [31:0] ent_w4_i [sma_pkg::SMA_ST_ENTRIES],
    input wire logic [47:0] da_i,
    input wire logic [47:0] sa_i,
    input wire logic [sma_pkg::SMA_FID_W-1:0] fid_i,
    output logic hit_o,
    output logic [sma_pkg::SMA_ST_IDX_W-1:0] hit_idx_o,
    output logic sa_drop_o
);
    import sma_pkg::*;
    logic [SMA_ST_ENTRIES-1:0] da_match;
    logic [SMA_ST_ENTRIES-1:0] sa_match;

    genvar e;
    generate
        for (e = 0; e < SMA_ST_ENTRIES; e++) begin : g_ent
            wire logic [47:0] mac = {ent_w3_i[e][SMA_MACH_W-1:0], ent_w4_i[e]};
            wire logic mc_grp = da_i[SMA_MC_BIT] && ent_w2_i[e][SMA_MGME_BIT];
            wire logic fid_ok = !mc_grp
                || ent_w3_i[e][SMA_FID_LSB +: SMA_FID_W] == fid_i;
            // invalid entries never match
            assign da_match[e] = ent_w1_i[e][SMA_VALID_BIT]
                && mac == da_i && fid_ok;
            assign sa_match[e] = ent_w1_i[e][SMA_VALID_BIT] && mac == sa_i
                && ent_w1_i[e][SMA_SRC_DROP_BIT];
        end
    endgenerate

    // lowest index wins
    always_comb begin
        hit_idx_o = '0;
        for (int i = SMA_ST_ENTRIES - 1; i >= 0; i--) begin
            if (da_match[i]) begin
                hit_idx_o = SMA_ST_IDX_W'(i);
            end
        end
    end
    assign hit_o = |da_match;
    assign sa_drop_o = |sa_match;
endmodule
`default_nettype wire

// ---- verilog/sma_table_access.sv ----
// indirect host access to static and reserved multicast tables, plus lookup
// assumes synchronous host strobes and a dynamic table result per lookup
//
// Overview of operation
// - bit 31 of word two enables port_state_a
// - port mask bits 6:0, bit 0 port 1
// - word three: group id 22:16, mac high
// - word four: mac low, read write, zero
// - sixteen static entries, reached only indirectly
// - each lookup searches every table
// - static entries never aged, host only
// - static result beats dynamic result
// - read start loads entry into data
// - go bit clears when operation completes
// - source match drop on bit 30
// - destination match drop on bit 29
// - priority 28:26, spanning group 2:0
// - bit 30 adds group id to multicast
// - 48 reserved addresses, six-bit index, masks
// - group write updates every member address
`timescale 1ns/1ps
`default_nettype none
module sma_table_access (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_wdata_i,
    output logic [31:0] reg_rdata_o,
    output logic reg_rvalid_o,
    output logic [31:0] data1_o,
    output logic [31:0] data2_o,
    output logic [31:0] data3_o,
    output logic [31:0] data4_o,
    input wire logic lkp_req_i,
    input wire logic [47:0] lkp_da_i,
    input wire logic [47:0] lkp_sa_i,
    input wire logic [sma_pkg::SMA_FID_W-1:0] lkp_fid_i,
    input wire logic dyn_hit_i,
    input wire logic dyn_static_i,
    input wire logic dyn_port_state_a_i,
    input wire logic dyn_dst_drop_i,
    input wire logic [sma_pkg::SMA_PORTS-1:0] dyn_fwd_i,
    output logic lkp_valid_o,
    output logic lkp_hit_o,
    output logic lkp_static_o,
    output logic [sma_pkg::SMA_PORTS-1:0] lkp_fwd_o,
    output logic lkp_port_state_a_o,
    output logic lkp_drop_o,
    output logic lkp_sa_drop_o,
    output logic [sma_pkg::SMA_PRIO_W-1:0] lkp_prio_o,
    output logic [sma_pkg::SMA_STG_W-1:0] lkp_stg_o
);
    import sma_pkg::*;
    sma_state_t state_r, state_nxt;
    logic [SMA_IDX_W-1:0] idx_r;
    logic tbl_r;
    logic act_r;
    logic [31:0] d1_r, d2_r, d3_r, d4_r;
    logic [31:0] st_w1_r [SMA_ST_ENTRIES];
    logic [31:0] st_w2_r [SMA_ST_ENTRIES];
    logic [31:0] st_w3_r [SMA_ST_ENTRIES];
    logic [31:0] st_w4_r [SMA_ST_ENTRIES];

    // register decode
    wire logic sel_ctrl = reg_addr_i == SMA_OFS_CTRL;
    wire logic sel_d1 = reg_addr_i == SMA_OFS_DATA1;
    wire logic sel_d2 = reg_addr_i == SMA_OFS_DATA2;
    wire logic sel_d3 = reg_addr_i == SMA_OFS_DATA3;
    wire logic sel_d4 = reg_addr_i == SMA_OFS_DATA4;
    wire logic busy = state_r == SMA_EXEC;
    wire logic ctrl_wr = reg_wr_i && sel_ctrl && !busy;
    wire logic start = ctrl_wr && reg_wdata_i[SMA_CTRL_GO_BIT];
    wire logic [SMA_ST_IDX_W-1:0] st_idx = idx_r[SMA_ST_IDX_W-1:0];
    wire logic st_wr = busy && !tbl_r && !act_r;
    wire logic st_rd = busy && !tbl_r && act_r;
    wire logic rmc_wr = busy && tbl_r && !act_r;
    wire logic rmc_rd = busy && tbl_r && act_r;
    wire logic [31:0] ctrl_word = {22'h0, act_r, tbl_r, busy, 1'b0, idx_r};
    logic [SMA_PORTS-1:0] rmc_rd_mask;
    logic rmc_in_range;
    logic [SMA_PORTS-1:0] rmc_lkp_mask;
    logic st_hit;
    logic [SMA_ST_IDX_W-1:0] st_hit_idx;
    logic st_sa_drop;
    logic [31:0] rd_mux;

    // op engine: go stays set for exactly one execute cycle
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            SMA_IDLE: begin
                if (start) begin
                    state_nxt = SMA_EXEC;
                end
            end
            SMA_EXEC: begin
                state_nxt = SMA_IDLE;
            end
            default: begin
                state_nxt = SMA_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r <= SMA_IDLE;
            idx_r <= '0;
            tbl_r <= 1'b0;
            act_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (ctrl_wr) begin
                idx_r <= reg_wdata_i[SMA_CTRL_IDX_LSB +: SMA_IDX_W];
                tbl_r <= reg_wdata_i[SMA_CTRL_TBL_BIT];
                act_r <= reg_wdata_i[SMA_CTRL_ACT_BIT];
            end
        end
    end

    // shared data bank; a table read load wins over a host write
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            d1_r <= SMA_RST_WORD;
            d2_r <= SMA_RST_WORD;
            d3_r <= SMA_RST_WORD;
            d4_r <= SMA_RST_WORD;
        end else if (st_rd) begin
            d1_r <= st_w1_r[st_idx];
            d2_r <= st_w2_r[st_idx];
            d3_r <= st_w3_r[st_idx];
            d4_r <= st_w4_r[st_idx];
        end else if (rmc_rd) begin
            d2_r <= {d2_r[31:30], 23'h0, rmc_rd_mask};
        end else if (reg_wr_i) begin
            if (sel_d1) begin
                d1_r <= reg_wdata_i & SMA_D1_MASK;
            end else if (sel_d2) begin
                d2_r <= reg_wdata_i & SMA_D2_MASK;
            end else if (sel_d3) begin
                d3_r <= reg_wdata_i & SMA_D3_MASK;
            end else if (sel_d4) begin
                d4_r <= reg_wdata_i & SMA_D4_MASK;
            end
        end
    end

    genvar e;
    generate
        for (e = 0; e < SMA_ST_ENTRIES; e++) begin : g_st
            // host write is the only update path, nothing ages these
            always_ff @(posedge core_clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    st_w1_r[e] <= SMA_RST_WORD;
                    st_w2_r[e] <= SMA_RST_WORD;
                    st_w3_r[e] <= SMA_RST_WORD;
                    st_w4_r[e] <= SMA_RST_WORD;
                end else if (st_wr && st_idx == SMA_ST_IDX_W'(e)) begin
                    st_w1_r[e] <= d1_r;
                    st_w2_r[e] <= d2_r;
                    st_w3_r[e] <= d3_r;
                    st_w4_r[e] <= d4_r;
                end
            end
        end
    endgenerate

    sma_rmc_table u_rmc (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .wr_i(rmc_wr),
        .wr_idx_i(idx_r),
        .wr_mask_i(d2_r[SMA_FWD_LSB +: SMA_PORTS]),
        .rd_idx_i(idx_r),
        .rd_mask_o(rmc_rd_mask),
        .lkp_low_i(lkp_da_i[7:0]),
        .lkp_in_range_o(rmc_in_range),
        .lkp_mask_o(rmc_lkp_mask)
    );

    sma_static_lookup u_st_lkp (
        .ent_w1_i(st_w1_r),
        .ent_w2_i(st_w2_r),
        .ent_w3_i(st_w3_r),
        .ent_w4_i(st_w4_r),
        .da_i(lkp_da_i),
        .sa_i(lkp_sa_i),
        .fid_i(lkp_fid_i),
        .hit_o(st_hit),
        .hit_idx_o(st_hit_idx),
        .sa_drop_o(st_sa_drop)
    );

    // result selection: static table, static dynamic entry, reserved, dynamic
    wire logic [31:0] hw1 = st_w1_r[st_hit_idx];
    wire logic [31:0] hw2 = st_w2_r[st_hit_idx];
    wire logic rmc_hit = lkp_da_i[47:8] == SMA_RMC_PREFIX && rmc_in_range;
    wire logic dyn_static_hit = dyn_hit_i && dyn_static_i;
    wire logic [SMA_PORTS-1:0] res_fwd = st_hit ? hw2[SMA_FWD_LSB +: SMA_PORTS]
        : dyn_static_hit ? dyn_fwd_i
        : rmc_hit ? rmc_lkp_mask
        : dyn_hit_i ? dyn_fwd_i : '0;
    wire logic res_ovr = st_hit ? hw2[SMA_OVR_BIT]
        : (dyn_hit_i && !rmc_hit) || dyn_static_hit ? dyn_port_state_a_i
        : 1'b0;
    wire logic res_drop = st_hit ? hw1[SMA_DST_DROP_BIT]
        : (dyn_hit_i && !rmc_hit) || dyn_static_hit ? dyn_dst_drop_i
        : 1'b0;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lkp_valid_o <= 1'b0;
            lkp_hit_o <= 1'b0;
            lkp_static_o <= 1'b0;
            lkp_fwd_o <= '0;
            lkp_port_state_a_o <= 1'b0;
            lkp_drop_o <= 1'b0;
            lkp_sa_drop_o <= 1'b0;
            lkp_prio_o <= '0;
            lkp_stg_o <= '0;
        end else begin
            lkp_valid_o <= lkp_req_i;
            if (lkp_req_i) begin
                lkp_hit_o <= st_hit || rmc_hit || dyn_hit_i;
                lkp_static_o <= st_hit || dyn_static_hit;
                lkp_fwd_o <= res_fwd;
                lkp_port_state_a_o <= res_ovr;
                lkp_drop_o <= res_drop;
                lkp_sa_drop_o <= st_sa_drop;
                lkp_prio_o <= st_hit ? hw1[SMA_PRIO_LSB +: SMA_PRIO_W] : '0;
                lkp_stg_o <= st_hit ? hw1[SMA_STG_LSB +: SMA_STG_W] : '0;
            end
        end
    end

    // register read, one cycle latency, unmapped reads zero
    assign rd_mux = sel_ctrl ? ctrl_word
        : sel_d1 ? d1_r
        : sel_d2 ? d2_r
        : sel_d3 ? d3_r
        : sel_d4 ? d4_r : 32'h0000_0000;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= '0;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= rd_mux;
            end
        end
    end

    assign data1_o = d1_r;
    assign data2_o = d2_r;
    assign data3_o = d3_r;
    assign data4_o = d4_r;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_start;
        state_r == SMA_IDLE && reg_wr_i && sel_ctrl
            && reg_wdata_i[SMA_CTRL_GO_BIT];
    endsequence
    sequence s_done;
        busy ##1 !busy;
    endsequence

    a_go_self_clear: assert property (s_start |=> s_done)
        else $error("go bit did not clear after one cycle");
    a_busy_ignore: assert property (busy && reg_wr_i && sel_ctrl
        |=> $stable(idx_r) && $stable(tbl_r) && !busy)
        else $error("control write accepted during operation");
    a_static_read: assert property (st_rd |=> d4_r == st_w4_r[$past(st_idx)]
        && d1_r == st_w1_r[$past(st_idx)])
        else $error("static read did not load data bank");
    a_static_write: assert property (st_wr
        |=> st_w3_r[$past(st_idx)] == $past(d3_r))
        else $error("static write did not store entry");
    a_rmc_group: assert property (rmc_wr && idx_r < SMA_IDX_W'(SMA_RMC_ADDRS)
        |=> u_rmc.grp_mask_r[$past(idx_r) / SMA_RMC_PER_GRP]
            == $past(d2_r[SMA_PORTS-1:0]))
        else $error("reserved group mask not updated");
    a_reserved_zero: assert property (reg_rd_i && sel_d3
        |=> reg_rvalid_o && reg_rdata_o[31:23] == 9'h000)
        else $error("reserved bits of word three not zero");
    a_static_wins: assert property (lkp_req_i && st_hit && dyn_hit_i
        |=> lkp_static_o && lkp_fwd_o == $past(hw2[SMA_PORTS-1:0]))
        else $error("dynamic result beat static result");
    a_dest_drop: assert property (lkp_req_i && st_hit
        |=> lkp_drop_o == $past(hw1[SMA_DST_DROP_BIT]))
        else $error("destination drop mismatch");
    a_stable_table: assert property (!st_wr |=> $stable(st_w1_r[0]))
        else $error("static entry changed without host write");
endmodule
`default_nettype wire

// ---- bench/sma_table_access_test.sv ----
// self-checking bench for the static and reserved multicast table access
// assumes sma_pkg and the design files are compiled before this file
`timescale 1ns/1ps
`default_nettype none
module sma_table_access_test;
    import sma_pkg::*;
    logic core_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [11:0] reg_addr_i = 12'h000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [31:0] reg_wdata_i = 32'h0000_0000;
    logic [31:0] reg_rdata_o, data1_o, data2_o, data3_o, data4_o;
    logic reg_rvalid_o, lkp_valid_o, lkp_hit_o, lkp_static_o;
    logic lkp_port_state_a_o, lkp_drop_o, lkp_sa_drop_o;
    logic [SMA_PORTS-1:0] lkp_fwd_o;
    logic [SMA_PRIO_W-1:0] lkp_prio_o;
    logic [SMA_STG_W-1:0] lkp_stg_o;
    logic lkp_req_i = 1'b0;
    logic [47:0] lkp_da_i = 48'h0;
    logic [47:0] lkp_sa_i = 48'h0;
    logic [SMA_FID_W-1:0] lkp_fid_i = 7'h00;
    logic dyn_hit_i = 1'b0;
    logic dyn_static_i = 1'b0;
    logic dyn_port_state_a_i = 1'b0;
    logic dyn_dst_drop_i = 1'b0;
    logic [SMA_PORTS-1:0] dyn_fwd_i = 7'h00;
    logic [11:0] lkp_word;
    int n_fail = 0;
    int num_checks = 0;
    // rows: address, written word, word read back
    localparam logic [75:0] ROWS [5] = '{
        {12'h420, 32'hffff_ffff, 32'hfc00_0007},
        {12'h424, 32'hffff_ffff, 32'hc000_007f},
        {12'h428, 32'hffff_ffff, 32'h007f_ffff},
        {12'h42c, 32'ha5a5_5a5a, 32'ha5a5_5a5a},
        {12'h500, 32'hffff_ffff, 32'h0000_0000}};
    localparam logic [47:0] MAC = 48'h0a0b_0c0d_0e0f;

    assign lkp_word = {lkp_hit_o, lkp_static_o, lkp_port_state_a_o, lkp_drop_o,
                       lkp_sa_drop_o, lkp_fwd_o};

    sma_table_access i_sma_table_access (
        .core_clk_i(core_clk_i), .resetn_i(resetn_i),
        .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .reg_rvalid_o(reg_rvalid_o), .data1_o(data1_o), .data2_o(data2_o),
        .data3_o(data3_o), .data4_o(data4_o), .lkp_req_i(lkp_req_i),
        .lkp_da_i(lkp_da_i), .lkp_sa_i(lkp_sa_i), .lkp_fid_i(lkp_fid_i),
        .dyn_hit_i(dyn_hit_i), .dyn_static_i(dyn_static_i),
        .dyn_port_state_a_i(dyn_port_state_a_i), .dyn_dst_drop_i(dyn_dst_drop_i),
        .dyn_fwd_i(dyn_fwd_i), .lkp_valid_o(lkp_valid_o),
        .lkp_hit_o(lkp_hit_o), .lkp_static_o(lkp_static_o),
        .lkp_fwd_o(lkp_fwd_o), .lkp_port_state_a_o(lkp_port_state_a_o),
        .lkp_drop_o(lkp_drop_o), .lkp_sa_drop_o(lkp_sa_drop_o),
        .lkp_prio_o(lkp_prio_o), .lkp_stg_o(lkp_stg_o));

    initial begin
        forever #12.5 core_clk_i = ~core_clk_i;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic reg_write(input logic [11:0] addr, input logic [31:0] d);
        @(posedge core_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= addr;
        reg_wdata_i <= d;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic reg_read(input logic [11:0] addr, output logic [31:0] d);
        int i;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= addr;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        for (i = 0; i < 4 && reg_rvalid_o !== 1'b1; i++) begin
            @(posedge core_clk_i);
            #1;
        end
        if (reg_rvalid_o !== 1'b1) begin
            n_fail++;
            report_and_stop();
        end
        d = reg_rdata_o;
    endtask

    // polls the control word until the go bit has dropped
    task automatic wait_done();
        logic [31:0] c;
        int i;
        c = 32'hffff_ffff;
        for (i = 0; i < 8 && c[SMA_CTRL_GO_BIT] !== 1'b0; i++) begin
            reg_read(SMA_OFS_CTRL, c);
        end
        if (c[SMA_CTRL_GO_BIT] !== 1'b0) begin
            n_fail++;
            report_and_stop();
        end
    endtask

    task automatic lookup(input logic [47:0] da, input logic [47:0] sa);
        @(posedge core_clk_i);
        lkp_req_i <= 1'b1;
        lkp_da_i <= da;
        lkp_sa_i <= sa;
        @(posedge core_clk_i);
        lkp_req_i <= 1'b0;
        #1;
        check("lookup valid", 32'(lkp_valid_o), 32'h1);
    endtask

    initial begin
        logic [31:0] rd;
        int k;
        repeat (8) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        for (k = 0; k < 4; k++) begin
            reg_read(SMA_OFS_DATA1 + 12'(4 * k), rd);
            check("reset word", rd, SMA_RST_WORD);
        end
        for (k = 0; k < 5; k++) begin
            reg_write(ROWS[k][75:64], ROWS[k][63:32]);
            reg_read(ROWS[k][75:64], rd);
            check("data word", rd, ROWS[k][31:0]);
        end
        // static entry 15, then a second start while busy
        reg_write(SMA_OFS_DATA1, 32'hf400_0003);
        reg_write(SMA_OFS_DATA2, 32'h8000_0045);
        reg_write(SMA_OFS_DATA3, 32'h0012_0a0b);
        reg_write(SMA_OFS_DATA4, 32'h0c0d_0e0f);
        @(posedge core_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= SMA_OFS_CTRL;
        reg_wdata_i <= 32'h0000_008f;
        @(posedge core_clk_i);
        reg_wdata_i <= 32'h0000_0280;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
        wait_done();
        check("bank kept", data1_o, 32'hf400_0003);
        for (k = 0; k < 4; k++) begin
            reg_write(SMA_OFS_DATA1 + 12'(4 * k), 32'h0000_0000);
        end
        reg_write(SMA_OFS_CTRL, 32'h0000_028f);
        wait_done();
        check("read word1", data1_o, 32'hf400_0003);
        check("read word2", data2_o, 32'h8000_0045);
        check("read word3", data3_o, 32'h0012_0a0b);
        check("read word4", data4_o, 32'h0c0d_0e0f);
        // lookups against the stored entry and the dynamic result
        @(posedge core_clk_i);
        dyn_hit_i <= 1'b1;
        dyn_static_i <= 1'b1;
        dyn_fwd_i <= 7'h7f;
        lookup(MAC, MAC);
        check("static hit", 32'(lkp_word), 32'hfc5);
        check("priority", 32'(lkp_prio_o), 32'h5);
        check("tree group", 32'(lkp_stg_o), 32'h3);
        reg_write(SMA_OFS_DATA1, 32'h7400_0003);
        reg_write(SMA_OFS_CTRL, 32'h0000_008f);
        wait_done();
        @(posedge core_clk_i);
        dyn_port_state_a_i <= 1'b1;
        dyn_dst_drop_i <= 1'b1;
        lookup(MAC, MAC);
        check("invalid entry", 32'(lkp_word), 32'hf7f);
        @(posedge core_clk_i);
        dyn_hit_i <= 1'b0;
        dyn_static_i <= 1'b0;
        dyn_port_state_a_i <= 1'b0;
        dyn_dst_drop_i <= 1'b0;
        lookup(48'h0000_1111_2222, 48'h0000_3333_4444);
        check("miss", 32'(lkp_word), 32'h0000_0000);
        // reserved multicast group write through member index 2
        reg_write(SMA_OFS_DATA2, 32'h0000_002a);
        reg_write(SMA_OFS_CTRL, 32'h0000_0182);
        wait_done();
        reg_write(SMA_OFS_DATA2, 32'h0000_0000);
        reg_write(SMA_OFS_CTRL, 32'h0000_0385);
        wait_done();
        check("group member", data2_o, 32'h0000_002a);
        reg_write(SMA_OFS_CTRL, 32'h0000_0386);
        wait_done();
        check("next group", data2_o, 32'h0000_0000);
        lookup(48'h0180_c200_0004, 48'h0000_3333_4444);
        check("reserved fwd", 32'(lkp_fwd_o), 32'h0000_002a);
        // multicast entry 3 that also matches on the group id
        reg_write(SMA_OFS_DATA1, 32'h8000_0000);
        reg_write(SMA_OFS_DATA2, 32'h4000_0011);
        reg_write(SMA_OFS_DATA3, 32'h0005_0100);
        reg_write(SMA_OFS_DATA4, 32'h0000_0001);
        reg_write(SMA_OFS_CTRL, 32'h0000_0083);
        wait_done();
        @(posedge core_clk_i);
        lkp_fid_i <= 7'h05;
        lookup(48'h0100_0000_0001, 48'h0000_3333_4444);
        check("group match", 32'(lkp_word), 32'hc11);
        @(posedge core_clk_i);
        lkp_fid_i <= 7'h06;
        lookup(48'h0100_0000_0001, 48'h0000_3333_4444);
        check("group differs", 32'(lkp_word), 32'h000);
        // reset in mid-run clears bank, tables and results
        @(posedge core_clk_i);
        resetn_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        lkp_fid_i <= 7'h05;
        check("reset bank", data2_o, SMA_RST_WORD);
        check("reset result", 32'(lkp_word), 32'h000);
        reg_write(SMA_OFS_CTRL, 32'h0000_0382);
        wait_done();
        check("reset group", data2_o, 32'h0000_0000);
        lookup(48'h0100_0000_0001, 48'h0000_3333_4444);
        check("reset entry", 32'(lkp_word), 32'h000);
        report_and_stop();
    end
endmodule
`default_nettype wire
